/* File: vmsr_regs.vh */
`ifndef VMSR_REGS_VH
`define VMSR_REGS_VH
// Notes on behaviour
// - Low-margin target is command 26h, written by Write Word, read by Read Word.
// - Margin Low selects output target equal to low-margin value plus trim.
// - Low-margin value is a relative factor lowering the command, LSB from output mode.
// - Margin moves ramp at the programmed output slew rate.
// - Low-margin value sits in bits 9:0; bits 15:10 read zero.
// - Restore loads 496 when default bit is 0, 488 when it is 1.
// - Store derives default bit 0 for values 492 or more, else 1.
// - Out-of-range low-margin write is invalid data: set status, notify host.
// - Slew rate at 27h governs normal changes, not turn-on or turn-off ramps.
// - Slew exponent bits 15:11 read fixed 11101b, minus three.
// - Writable slew mantissa in bits 7:0; unused mantissa bits read zero.
// - Writes to read-only slew bits are ignored and leave values unchanged.
// - Mantissa reads back as written; slew uses the highest setting whose lower bound it reaches; restore loads fixed mantissa.
// - Mantissa ranges map onto eight slew settings from 0.625 to 19.53.

// Command codes.
`define VMSR_CMD_MARGIN_LOW 8'h26
`define VMSR_CMD_SLEW_RATE 8'h27

// Low-margin field and restore values.
`define VMSR_ML_MSB 9
`define VMSR_ML_DFLT0 10'h1f0
`define VMSR_ML_DFLT1 10'h1e8
`define VMSR_ML_THRESH 10'h1ec
`define VMSR_ML_RSVD_ZERO 6'h00

// Operation margin field value for Margin Low.
`define VMSR_OP_MARGIN_LOW 2'h1

// Slew register layout.
`define VMSR_SLEW_EXP 5'h1d
`define VMSR_SLEW_PAD 3'h0
`define VMSR_SLEW_MSB 7

// Lower bound of each supported slew setting; also the restore mantissa.
`define VMSR_SLEW_B1 8'h08
`define VMSR_SLEW_B2 8'h0f
`define VMSR_SLEW_B3 8'h1e
`define VMSR_SLEW_B4 8'h2a
`define VMSR_SLEW_B5 8'h3e
`define VMSR_SLEW_B6 8'h54
`define VMSR_SLEW_B7 8'h90
`define VMSR_SLEW_R0 8'h00

`endif

/* File: vmsr_slew_quant.v */
`default_nettype none
`include "vmsr_regs.vh"

module vmsr_slew_quant (
   // Stored mantissa
   input wire [7:0] mantissa,
   // Selected slew setting, 0 is slowest
   output reg [2:0] setting
);

   always @* begin
      setting = 3'h0;
      if (mantissa >= `VMSR_SLEW_B7) begin
         setting = 3'h7;
      end else if (mantissa >= `VMSR_SLEW_B6) begin
         setting = 3'h6;
      end else if (mantissa >= `VMSR_SLEW_B5) begin
         setting = 3'h5;
      end else if (mantissa >= `VMSR_SLEW_B4) begin
         setting = 3'h4;
      end else if (mantissa >= `VMSR_SLEW_B3) begin
         setting = 3'h3;
      end else if (mantissa >= `VMSR_SLEW_B2) begin
         setting = 3'h2;
      end else if (mantissa >= `VMSR_SLEW_B1) begin
         setting = 3'h1;
      end
   end

endmodule // vmsr_slew_quant
`default_nettype wire

/* File: vmsr_bank.v */
`default_nettype none
`include "vmsr_regs.vh"

module vmsr_bank (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Decoded command port from the bus protocol engine
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   output reg cmd_ack_q,
   output reg cmd_unsup_q,
   output reg [15:0] rd_data_q,
   // Non-volatile store and restore
   input wire nvm_restore,
   input wire nvm_store,
   input wire nvm_lo_dflt,
   input wire [2:0] nvm_slew_sel,
   output reg low_margin_default_select_q,
   output reg [2:0] nvm_slew_sel_q,
   // Regulation context
   input wire [1:0] op_margin,
   input wire [15:0] vout_command,
   input wire [15:0] vout_trim,
   input wire [3:0] rel_frac_bits,
   input wire [15:0] vout_min,
   input wire [15:0] vout_max,
   input wire onoff_ramp,
   // Regulation outputs
   output reg [15:0] vout_target_q,
   output reg margin_low_active_q,
   output reg [2:0] slew_sel_q,
   output reg slew_enable_q,
   // Status
   input wire clear_status,
   output reg status_invalid_data_q,
   output reg host_notify_q
);

   reg [`VMSR_ML_MSB:0] ml_q;
   reg [`VMSR_ML_MSB:0] ml_d;
   reg [`VMSR_SLEW_MSB:0] slew_q;
   reg [`VMSR_SLEW_MSB:0] slew_d;
   wire [2:0] slew_setting;
   wire wr_ml;
   wire wr_slew;
   wire rd_req;
   wire mapped;
   wire signed [17:0] wr_target;
   wire signed [17:0] live_target;
   wire wr_bad;
   wire margin_low;

   // Relative factor times the command, shifted by the mode's fraction
   // bits, plus trim. Saturates at the top of 18 bits so that a small
   // fraction count cannot wrap a huge target into the valid range.
   function signed [17:0] vmsr_target;
      input [15:0] cmd;
      input [`VMSR_ML_MSB:0] ml;
      input [15:0] trim;
      input [3:0] sh;
      reg [25:0] prod;
      reg [16:0] base;
      reg signed [18:0] sum;
      begin
         prod = ({10'h000, cmd} * {16'h0000, ml}) >> sh;
         base = (|prod[25:17]) ? 17'h1ffff : prod[16:0];
         sum = $signed({2'b00, base}) + $signed({{3{trim[15]}}, trim});
         if (sum > $signed(19'h1ffff)) begin
            vmsr_target = 18'h1ffff;
         end else begin
            vmsr_target = sum[17:0];
         end
      end
   endfunction

   // Fixed restore mantissa for each supported slew setting.
   function [7:0] vmsr_slew_restore;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: vmsr_slew_restore = `VMSR_SLEW_B1;
            3'h2: vmsr_slew_restore = `VMSR_SLEW_B2;
            3'h3: vmsr_slew_restore = `VMSR_SLEW_B3;
            3'h4: vmsr_slew_restore = `VMSR_SLEW_B4;
            3'h5: vmsr_slew_restore = `VMSR_SLEW_B5;
            3'h6: vmsr_slew_restore = `VMSR_SLEW_B6;
            3'h7: vmsr_slew_restore = `VMSR_SLEW_B7;
            default: vmsr_slew_restore = `VMSR_SLEW_R0;
         endcase
      end
   endfunction

   assign wr_ml = cmd_valid && cmd_write && (cmd_code == `VMSR_CMD_MARGIN_LOW);
   assign wr_slew = cmd_valid && cmd_write && (cmd_code == `VMSR_CMD_SLEW_RATE);
   assign rd_req = cmd_valid && !cmd_write;
   assign mapped = (cmd_code == `VMSR_CMD_MARGIN_LOW) || (cmd_code == `VMSR_CMD_SLEW_RATE);

   // Upper bits of the written word never reach the register.
   assign wr_target = vmsr_target(vout_command, cmd_wdata[`VMSR_ML_MSB:0], vout_trim, rel_frac_bits);
   assign wr_bad = (wr_target < $signed({2'b00, vout_min})) ||
                   (wr_target > $signed({2'b00, vout_max}));
   assign live_target = vmsr_target(vout_command, ml_q, vout_trim, rel_frac_bits);
   assign margin_low = (op_margin == `VMSR_OP_MARGIN_LOW);

   vmsr_slew_quant u_quant (
      .mantissa(slew_q),
      .setting(slew_setting)
   );

   // Restore has priority over a host write landing in the same cycle,
   // so the register always reflects the freshly loaded defaults.
   always @* begin
      ml_d = ml_q;
      slew_d = slew_q;
      if (nvm_restore) begin
         ml_d = nvm_lo_dflt ? `VMSR_ML_DFLT1 : `VMSR_ML_DFLT0;
         slew_d = vmsr_slew_restore(nvm_slew_sel);
      end else begin
         if (wr_ml && mapped && !wr_bad) begin
            ml_d = cmd_wdata[`VMSR_ML_MSB:0];
         end
         if (wr_slew) begin
            slew_d = cmd_wdata[`VMSR_SLEW_MSB:0];
         end
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ml_q <= `VMSR_ML_DFLT0;
         slew_q <= `VMSR_SLEW_R0;
      end else begin
         ml_q <= ml_d;
         slew_q <= slew_d;
      end
   end

   // Command answers, one cycle after the request.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cmd_ack_q <= 1'b0;
         cmd_unsup_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end else begin
         cmd_ack_q <= cmd_valid && mapped;
         cmd_unsup_q <= cmd_valid && !mapped;
         if (rd_req && (cmd_code == `VMSR_CMD_MARGIN_LOW)) begin
            rd_data_q <= {`VMSR_ML_RSVD_ZERO, ml_q};
         end else if (rd_req && (cmd_code == `VMSR_CMD_SLEW_RATE)) begin
            rd_data_q <= {`VMSR_SLEW_EXP, `VMSR_SLEW_PAD, slew_q};
         end else if (rd_req) begin
            rd_data_q <= 16'h0000;
         end
      end
   end

   // Invalid data flag; a new fault in the clearing cycle keeps it set.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status_invalid_data_q <= 1'b0;
         host_notify_q <= 1'b0;
      end else begin
         if (wr_ml && wr_bad && !nvm_restore) begin
            status_invalid_data_q <= 1'b1;
         end else if (clear_status) begin
            status_invalid_data_q <= 1'b0;
         end
         host_notify_q <= wr_ml && wr_bad && !nvm_restore;
      end
   end

   // Non-volatile image: one bit for the margin, a setting for the slew.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         low_margin_default_select_q <= 1'b0;
         nvm_slew_sel_q <= 3'h0;
      end else if (nvm_store) begin
         low_margin_default_select_q <= (ml_q < `VMSR_ML_THRESH);
         nvm_slew_sel_q <= slew_setting;
      end
   end

   // Regulation outputs. The slew setting is only honoured outside the
   // turn-on and turn-off ramps, which use their own timing.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         vout_target_q <= 16'h0000;
         margin_low_active_q <= 1'b0;
         slew_sel_q <= 3'h0;
         slew_enable_q <= 1'b0;
      end else begin
         margin_low_active_q <= margin_low;
         slew_sel_q <= slew_setting;
         slew_enable_q <= !onoff_ramp;
         if (!margin_low) begin
            vout_target_q <= vout_command;
         end else if (live_target < $signed(18'h00000)) begin
            vout_target_q <= 16'h0000;
         end else if (live_target[17:16] != 2'b00) begin
            vout_target_q <= 16'hffff;
         end else begin
            vout_target_q <= live_target[15:0];
         end
      end
   end

endmodule // vmsr_bank
`default_nettype wire

/* File: vmsr_bank_chk.sv */
`default_nettype none
module vmsr_bank_chk (
   // Watched ports
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [1:0] op_margin,
   input wire logic onoff_ramp,
   input wire logic [15:0] vout_command,
   input wire logic cmd_ack_q,
   input wire logic cmd_unsup_q,
   input wire logic [15:0] rd_data_q,
   input wire logic [15:0] vout_target_q,
   input wire logic margin_low_active_q,
   input wire logic slew_enable_q,
   input wire logic status_invalid_data_q,
   input wire logic host_notify_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire is_map = cmd_code == 8'h26 || cmd_code == 8'h27;
   wire is_rd = cmd_valid && !cmd_write;
   ack_mapped_a: assert property (cmd_valid && is_map |=> cmd_ack_q && !cmd_unsup_q)
      else $error("mapped command not acknowledged");
   unsup_code_a: assert property (cmd_valid && !is_map |=> cmd_unsup_q && !cmd_ack_q)
      else $error("unmapped command not refused");
   margin_rsvd_a: assert property (is_rd && cmd_code == 8'h26 |=> rd_data_q[15:10] == 6'h00)
      else $error("reserved margin bits not zero");
   slew_exp_a: assert property (is_rd && cmd_code == 8'h27 |=> rd_data_q[15:8] == 8'he8)
      else $error("slew exponent field wrong");
   margin_act_a: assert property (op_margin == 2'h1 |=> margin_low_active_q)
      else $error("margin low not active");
   target_cmd_a: assert property (op_margin != 2'h1 |=> vout_target_q == $past(vout_command))
      else $error("target does not follow command");
   slew_gate_a: assert property (1'b1 |=> slew_enable_q == !$past(onoff_ramp))
      else $error("slew enable wrong during ramp");
   notify_flag_a: assert property (host_notify_q |-> status_invalid_data_q)
      else $error("notify without status flag");
   cover property (cmd_valid && cmd_write && cmd_code == 8'h27);
   cover property (host_notify_q);
   cover property (margin_low_active_q);
   cover property (onoff_ramp && !slew_enable_q);
endmodule // vmsr_bank_chk
bind vmsr_bank vmsr_bank_chk vmsr_bank_chk_inst (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .cmd_valid(cmd_valid),
   .cmd_write(cmd_write),
   .cmd_code(cmd_code),
   .op_margin(op_margin),
   .onoff_ramp(onoff_ramp),
   .vout_command(vout_command),
   .cmd_ack_q(cmd_ack_q),
   .cmd_unsup_q(cmd_unsup_q),
   .rd_data_q(rd_data_q),
   .vout_target_q(vout_target_q),
   .margin_low_active_q(margin_low_active_q),
   .slew_enable_q(slew_enable_q),
   .status_invalid_data_q(status_invalid_data_q),
   .host_notify_q(host_notify_q)
);
`default_nettype wire

/* File: vmsr_host.sv */
`default_nettype none
module vmsr_host (
   // Command port toward the bank
   input wire logic ref_clk,
   output var logic cmd_valid,
   output var logic cmd_write,
   output var logic [7:0] cmd_code,
   output var logic [15:0] cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = 26'h0;
   // One word per command; code and data are inverted once released so stale data never looks valid.
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_wdata <= ~d;
   endtask
endmodule // vmsr_host
`default_nettype wire

/* File: test_vmsr_bank.sv */
`default_nettype none
module test_vmsr_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rstn = 1'b0, cmd_valid, cmd_write, cmd_ack_q, cmd_unsup_q;
   logic nvm_restore = 1'b0, nvm_store = 1'b0, nvm_lo_dflt = 1'b0, onoff_ramp = 1'b0, clear_status = 1'b0;
   logic low_margin_default_select_q, margin_low_active_q, slew_enable_q, status_invalid_data_q, host_notify_q;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rd_data_q, vout_target_q, vout_command = 16'h0400, vout_trim = 16'h0000;
   logic [15:0] vout_min = 16'h0000, vout_max = 16'hffff;
   logic [2:0] nvm_slew_sel = 3'h0, nvm_slew_sel_q, slew_sel_q;
   logic [1:0] op_margin = 2'h0;
   logic [3:0] rel_frac_bits = 4'h9;
   logic [16:0] notes[$], note;
   logic [31:0] seed = 32'd40, r;
   logic [7:0] bnd[8] = '{8'h00, 8'h08, 8'h0f, 8'h1e, 8'h2a, 8'h3e, 8'h54, 8'h90};
   int num_errors = 0, samples_checked = 0, sel = 0, notify_seen = 0;
   always #2.5 ref_clk = ~ref_clk;
   vmsr_bank vmsr_bank_inst (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .cmd_valid(cmd_valid),
      .cmd_write(cmd_write),
      .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata),
      .cmd_ack_q(cmd_ack_q),
      .cmd_unsup_q(cmd_unsup_q),
      .rd_data_q(rd_data_q),
      .nvm_restore(nvm_restore),
      .nvm_store(nvm_store),
      .nvm_lo_dflt(nvm_lo_dflt),
      .nvm_slew_sel(nvm_slew_sel),
      .low_margin_default_select_q(low_margin_default_select_q),
      .nvm_slew_sel_q(nvm_slew_sel_q),
      .op_margin(op_margin),
      .vout_command(vout_command),
      .vout_trim(vout_trim),
      .rel_frac_bits(rel_frac_bits),
      .vout_min(vout_min),
      .vout_max(vout_max),
      .onoff_ramp(onoff_ramp),
      .vout_target_q(vout_target_q),
      .margin_low_active_q(margin_low_active_q),
      .slew_sel_q(slew_sel_q),
      .slew_enable_q(slew_enable_q),
      .clear_status(clear_status),
      .status_invalid_data_q(status_invalid_data_q),
      .host_notify_q(host_notify_q)
   );
   vmsr_host vmsr_host_inst (
      .ref_clk(ref_clk),
      .cmd_valid(cmd_valid),
      .cmd_write(cmd_write),
      .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata)
   );
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Every command leaves a note; only reads carry a value worth comparing.
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
      notes.push_back({!w, e});
      vmsr_host_inst.xfer(w, c, d);
   endtask
   // Strobe 0 stores, 1 restores, anything else clears the status flag.
   task automatic pulse(input int k);
      @(posedge ref_clk);
      if (k == 0) nvm_store <= 1'b1;
      else if (k == 1) nvm_restore <= 1'b1;
      else clear_status <= 1'b1;
      @(posedge ref_clk);
      {nvm_store, nvm_restore, clear_status} <= 3'h0;
      repeat (2) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) if (cmd_ack_q || cmd_unsup_q) begin
      note = notes.pop_front();
      if (note[16]) check(rd_data_q, note[15:0]);
   end
   always @(posedge ref_clk) if (host_notify_q) notify_seen++;
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      cmd(0, 8'h26, 16'h0, 16'h01f0);
      cmd(0, 8'h27, 16'h0, 16'he800);
      cmd(0, 8'h55, 16'h0, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         cmd(1, 8'h27, {r[15:8], bnd[i]}, 16'h0);
         cmd(0, 8'h27, 16'h0, {8'he8, bnd[i]});
         check(16'(slew_sel_q), 16'(i));
         cmd(1, 8'h27, {8'h00, bnd[i] - 8'h01}, 16'h0);
         repeat (2) @(posedge ref_clk);
         check(16'(slew_sel_q), 16'((i + 7) % 8));
      end
      r = rnd();
      sel = 0;
      for (int j = 1; j < 8; j++) if (r[7:0] >= bnd[j]) sel = j;
      cmd(1, 8'h27, r[15:0], 16'h0);
      cmd(0, 8'h27, 16'h0, {8'he8, r[7:0]});
      check(16'(slew_sel_q), 16'(sel));
      cmd(1, 8'h26, 16'hfdec, 16'h0);
      cmd(0, 8'h26, 16'h0, 16'h01ec);
      pulse(0);
      check(16'(low_margin_default_select_q), 16'h0);
      check(16'(nvm_slew_sel_q), 16'(sel));
      cmd(1, 8'h26, 16'h01eb, 16'h0);
      pulse(0);
      check(16'(low_margin_default_select_q), 16'h1);
      nvm_lo_dflt <= 1'b1;
      nvm_slew_sel <= 3'h3;
      pulse(1);
      cmd(0, 8'h26, 16'h0, 16'h01e8);
      cmd(0, 8'h27, 16'h0, 16'he81e);
      vout_trim <= 16'h0005;
      op_margin <= 2'h1;
      repeat (3) @(posedge ref_clk);
      check(vout_target_q, 16'h03d5);
      check(16'(margin_low_active_q), 16'h1);
      vout_min <= 16'h0300;
      cmd(1, 8'h26, 16'h0100, 16'h0);
      cmd(0, 8'h26, 16'h0, 16'h01e8);
      check(16'(status_invalid_data_q), 16'h1);
      pulse(2);
      check(16'(status_invalid_data_q), 16'h0);
      check(16'(notify_seen), 16'h1);
      onoff_ramp <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check(16'(slew_enable_q), 16'h0);
      onoff_ramp <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(16'(slew_enable_q), 16'h1);
      // A reset in mid-run must bring back the defaults while margining stays selected.
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      cmd(0, 8'h26, 16'h0, 16'h01f0);
      cmd(0, 8'h27, 16'h0, 16'he800);
      check(vout_target_q, 16'h03e5);
      check(16'(status_invalid_data_q), 16'h0);
      repeat (3) @(posedge ref_clk);
      report_and_stop();
   end
endmodule // test_vmsr_bank
`default_nettype wire
